// ===== src/tsr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tsr_regs
	import tsr_pkg::*;
#(
	parameter logic [15:0] MAKER_ID = 16'h00A5, // arbitrary value
	parameter logic [15:0] PART_ID  = 16'h5A01  // arbitrary value
)(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// register access from the serial front end
	input  wire logic        ptr_wr,
	input  wire logic [7:0]  ptr_data,
	input  wire logic        reg_wr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	// converter side
	input  wire logic        conv_valid,
	input  wire logic [10:0] conv_temp,
	// outputs
	output logic             conv_run,
	output logic             event_pin
);
	initial begin
		if (MAKER_ID == PART_ID) $error("identity codes must differ");
	end

	logic [PTR_W-1:0] ptr_q;
	logic [15:0]      setup_q;
	logic [15:0]      upper_q, lower_q, crit_q;
	logic [10:0]      temp_q;
	logic [1:0]       res_q;
	logic             evt_q, irq_q, above_q, below_q, critf_q;
	logic             crit_hit, above_upper, below_lower;
	logic             any_lock, cond, raw_evt;
	logic [15:0]      rdata_d;

	function automatic logic sel(input logic [PTR_W-1:0] p, input logic [3:0] code);
		return p == code;
	endfunction

	assign any_lock = setup_q[SB_CRIT_LOCK] | setup_q[SB_WIN_LOCK];

	////////////////////////////////////////////////////////////////////////////
	// pointer: only low bits used, upper bits assumed zero by host
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ptr_q <= '0;
		end else if (ptr_wr) begin
			ptr_q <= ptr_data[PTR_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// setup register, writes accepted in shutdown too
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			setup_q <= SETUP_RESET;
		end else if (reg_wr && sel(ptr_q, PTR_SETUP)) begin
			if (!any_lock) begin
				setup_q[SB_HYST_HI:SB_HYST_LO] <= reg_wdata[SB_HYST_HI:SB_HYST_LO];
				setup_q[SB_POWER_DOWN_SELECT]    <= reg_wdata[SB_POWER_DOWN_SELECT];
				setup_q[SB_EVT_EN]  <= reg_wdata[SB_EVT_EN];
				setup_q[SB_EVT_POL] <= reg_wdata[SB_EVT_POL];
				setup_q[SB_EVT_MOD] <= reg_wdata[SB_EVT_MOD];
			end else if (!reg_wdata[SB_POWER_DOWN_SELECT]) begin
				setup_q[SB_POWER_DOWN_SELECT] <= 1'b0;
			end
			if (!setup_q[SB_WIN_LOCK]) begin
				setup_q[SB_EVT_SEL] <= reg_wdata[SB_EVT_SEL];
			end
			// locks only set by writes
			setup_q[SB_CRIT_LOCK] <= setup_q[SB_CRIT_LOCK] | reg_wdata[SB_CRIT_LOCK];
			setup_q[SB_WIN_LOCK]  <= setup_q[SB_WIN_LOCK] | reg_wdata[SB_WIN_LOCK];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// limit registers, guarded by locks
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			upper_q <= LIMIT_RESET;
			lower_q <= LIMIT_RESET;
			crit_q  <= LIMIT_RESET;
		end else if (reg_wr) begin
			if (sel(ptr_q, PTR_UPPER) && !setup_q[SB_WIN_LOCK]) upper_q <= reg_wdata & LIMIT_MASK;
			if (sel(ptr_q, PTR_LOWER) && !setup_q[SB_WIN_LOCK]) lower_q <= reg_wdata & LIMIT_MASK;
			if (sel(ptr_q, PTR_CRIT) && !setup_q[SB_CRIT_LOCK]) crit_q <= reg_wdata & LIMIT_MASK;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			res_q <= RES_RESET;
		end else if (reg_wr && sel(ptr_q, PTR_RES)) begin
			res_q <= reg_wdata[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// ambient reading holds last value in shutdown
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			temp_q <= '0;
		end else if (conv_valid && !setup_q[SB_POWER_DOWN_SELECT]) begin
			temp_q <= conv_temp;
		end
	end

	tsr_compare u_cmp (
		.temp_in     (temp_q),
		.upper_in    (upper_q[12:2]),
		.lower_in    (lower_q[12:2]),
		.crit_in     (crit_q[12:2]),
		.hyst_sel    (setup_q[SB_HYST_HI:SB_HYST_LO]),
		.above_prev  (above_q),
		.below_prev  (below_q),
		.crit_hit    (crit_hit),
		.above_upper (above_upper),
		.below_lower (below_lower)
	);

	assign cond = setup_q[SB_EVT_SEL] ? critf_q : (critf_q | above_q | below_q);

	////////////////////////////////////////////////////////////////////////////
	// event output: comparator follows condition, interrupt latches until cleared
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			above_q <= 1'b0;
			below_q <= 1'b0;
			critf_q <= 1'b0;
			irq_q   <= 1'b0;
		end else begin
			above_q <= above_upper;
			below_q <= below_lower;
			critf_q <= crit_hit;
			if (cond && setup_q[SB_EVT_EN]) begin
				irq_q <= 1'b1;
			end else if (reg_wr && sel(ptr_q, PTR_SETUP) && reg_wdata[SB_INT_CLR]) begin
				irq_q <= 1'b0;
			end
		end
	end

	assign raw_evt = setup_q[SB_EVT_EN] && (setup_q[SB_EVT_MOD] ? irq_q : cond);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			evt_q     <= 1'b0;
			event_pin <= 1'b0;
			conv_run  <= 1'b1;
		end else begin
			evt_q     <= raw_evt;
			event_pin <= raw_evt ~^ setup_q[SB_EVT_POL];
			conv_run  <= !setup_q[SB_POWER_DOWN_SELECT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read mux
	always_comb begin
		rdata_d = 16'h0000;
		unique case (ptr_q)
			PTR_CAP:   rdata_d = {11'h000, res_q, CAP_FIXED};
			PTR_SETUP: rdata_d = {5'h00, setup_q[10:6], 1'b0, evt_q, setup_q[3:0]};
			PTR_UPPER: rdata_d = upper_q;
			PTR_LOWER: rdata_d = lower_q;
			PTR_CRIT:  rdata_d = crit_q;
			PTR_AMB:   rdata_d = {critf_q, above_q, below_q, temp_q, 2'h0};
			PTR_MAKER: rdata_d = MAKER_ID;
			PTR_PART:  rdata_d = PART_ID;
			PTR_RES:   rdata_d = {14'h0000, res_q};
			default:   rdata_d = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	lock_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		setup_q[SB_CRIT_LOCK] |=> setup_q[SB_CRIT_LOCK]) else $error("crit lock cleared");
	win_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(setup_q[SB_WIN_LOCK]) |=> setup_q[SB_WIN_LOCK][*3]) else $error("window lock cleared");
	upper_locked_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		setup_q[SB_WIN_LOCK] |=> $stable(upper_q)) else $error("upper changed while locked");
	crit_locked_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		setup_q[SB_CRIT_LOCK] |=> $stable(crit_q)) else $error("crit changed while locked");
	cap_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ptr_q == PTR_CAP && $stable(ptr_q) |=> reg_rdata == {11'h000, $past(res_q), 3'h7}) else $error("capability wrong");
	temp_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		setup_q[SB_POWER_DOWN_SELECT] |=> $stable(temp_q)) else $error("reading moved in shutdown");
	limit_fmt_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(upper_q & ~LIMIT_MASK) == 16'h0000 && (crit_q & ~LIMIT_MASK) == 16'h0000) else $error("limit reserved bits set");
	ptr_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ptr_wr |=> ptr_q == $past(ptr_data[3:0])) else $error("pointer not loaded");
	evt_stat_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!setup_q[SB_EVT_EN] |=> !evt_q) else $error("status without enable");
	amb_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ptr_q == PTR_AMB && $stable(ptr_q) |=> reg_rdata[1:0] == 2'h0) else $error("reading low bits set");

	lock_set_c: cover property (@(posedge clk_sys) $rose(setup_q[SB_WIN_LOCK]));
	power_down_select_c: cover property (@(posedge clk_sys) $rose(setup_q[SB_POWER_DOWN_SELECT]));
	evt_c: cover property (@(posedge clk_sys) $rose(evt_q));
endmodule
`default_nettype wire

// ===== src/tsr_pkg.sv
// Behaviour
// - pointer 0-4 select capability, setup, limits
// - pointer 5-7 select reading and identities
// - pointer 8 selects resolution, others reserved
// - capability read-only, bits 15-5 zero
// - capability bits 4-3 show selected resolution
// - capability bit 2 reads one
// - capability bit 1 reads one
// - capability bit 0 always reads one
// - setup register 16 bits, bits 10-0 used
// - setup bits 10-9 select boundary hysteresis
// - setup bit 8 selects shutdown, reading holds
// - lock bits block limit register writes
// - setup bits 5 and 3-0 control event output
// - event status readable in setup register
// - all registers accessible during shutdown
// - lock bits sticky until power-on reset
// - limits hold 11-bit two's complement value
package tsr_pkg;
	localparam logic [3:0] PTR_CAP = 4'h0;
	localparam logic [3:0] PTR_SETUP = 4'h1;
	localparam logic [3:0] PTR_UPPER = 4'h2;
	localparam logic [3:0] PTR_LOWER = 4'h3;
	localparam logic [3:0] PTR_CRIT = 4'h4;
	localparam logic [3:0] PTR_AMB = 4'h5;
	localparam logic [3:0] PTR_MAKER = 4'h6;
	localparam logic [3:0] PTR_PART = 4'h7;
	localparam logic [3:0] PTR_RES = 4'h8;
	localparam int PTR_W = 4;
	// setup field positions
	localparam int SB_HYST_HI = 10;
	localparam int SB_HYST_LO = 9;
	localparam int SB_POWER_DOWN_SELECT = 8;
	localparam int SB_CRIT_LOCK = 7;
	localparam int SB_WIN_LOCK = 6;
	localparam int SB_INT_CLR = 5;
	localparam int SB_EVT_STAT = 4;
	localparam int SB_EVT_EN = 3;
	localparam int SB_EVT_SEL = 2;
	localparam int SB_EVT_POL = 1;
	localparam int SB_EVT_MOD = 0;
	localparam logic [15:0] SETUP_RESET = 16'h0000;
	localparam logic [15:0] LIMIT_MASK = 16'h1FFC;
	localparam logic [1:0] RES_RESET = 2'h1;
	localparam logic [2:0] CAP_FIXED = 3'h7;
	localparam logic [15:0] LIMIT_RESET = 16'h0000;
	// hysteresis in quarter-degree units: 0, 1.5, 3.0, 6.0
	localparam logic [4:0] HYST_Q0 = 5'h00;
	localparam logic [4:0] HYST_Q1 = 5'h06;
	localparam logic [4:0] HYST_Q2 = 5'h0C;
	localparam logic [4:0] HYST_Q3 = 5'h18;
endpackage

// ===== src/tsr_compare.sv
`timescale 1ns/1ps
`default_nettype none
module tsr_compare
	import tsr_pkg::*;
(
	// temperature and limits, 11-bit quarter degree two's complement
	input  wire logic signed [10:0] temp_in,
	input  wire logic signed [10:0] upper_in,
	input  wire logic signed [10:0] lower_in,
	input  wire logic signed [10:0] crit_in,
	input  wire logic        [1:0]  hyst_sel,
	input  wire logic               above_prev,
	input  wire logic               below_prev,
	// comparison results
	output logic                    crit_hit,
	output logic                    above_upper,
	output logic                    below_lower
);
	logic signed [12:0] hyst;
	always_comb begin
		unique case (hyst_sel)
			2'h0: hyst = 13'(HYST_Q0);
			2'h1: hyst = 13'(HYST_Q1);
			2'h2: hyst = 13'(HYST_Q2);
			2'h3: hyst = 13'(HYST_Q3);
		endcase
	end
	// once tripped, the upper flag releases only at or below the limit minus hysteresis, the lower flag only at or above the limit plus hysteresis
	always_comb begin
		crit_hit = 13'(temp_in) >= 13'(crit_in);
		if (above_prev) begin
			above_upper = 13'(temp_in) > 13'(upper_in) - hyst;
		end else begin
			above_upper = 13'(temp_in) > 13'(upper_in);
		end
		if (below_prev) begin
			below_lower = 13'(temp_in) < 13'(lower_in) + hyst;
		end else begin
			below_lower = 13'(temp_in) < 13'(lower_in);
		end
	end
endmodule
`default_nettype wire

// ===== dv/tsr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsr_host_model (
	// clock
	input  wire logic        clk_sys,
	// register access
	output logic             ptr_wr,
	output logic [7:0]       ptr_data,
	output logic             reg_wr,
	output logic [15:0]      reg_wdata
);
	initial begin
		ptr_wr = 1'b0;
		ptr_data = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 16'h0000;
	end

	////////////////////////////////////////////////////////////////
	// pointer load, one cycle, lines scrambled once released
	task automatic set_ptr(input logic [3:0] p);
		@(negedge clk_sys);
		ptr_data = {4'h0, p};
		ptr_wr = 1'b1;
		@(negedge clk_sys);
		ptr_wr = 1'b0;
		ptr_data = {4'h0, ~p};
	endtask

	// register write through the pointer
	task automatic wr(input logic [3:0] p, input logic [15:0] d);
		set_ptr(p);
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
endmodule
`default_nettype wire

// ===== dv/temp_sensor_register_map_bench.sv
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_register_map_bench;
	import tsr_pkg::*;
	typedef struct packed {logic [1:0] sel; logic [15:0] val;} tsr_chk_t;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        ptr_wr, reg_wr, conv_run, event_pin;
	logic        conv_valid = 1'b0;
	logic [10:0] conv_temp = 11'h000;
	logic [7:0]  ptr_data;
	logic [15:0] reg_wdata, reg_rdata, lim, got;
	int          fail_count = 0, checks_done = 0, cyc = 0;
	tsr_chk_t    exp_q[$], e;
	event        look_ev;

	always #2.5 clk_sys = ~clk_sys;

	tsr_regs #(.MAKER_ID(16'h00C3), .PART_ID(16'h3C02)) i_tsr_regs ( // arbitrary identity values
		.clk_sys(clk_sys), .rst_n(rst_n), .ptr_wr(ptr_wr), .ptr_data(ptr_data),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.conv_valid(conv_valid), .conv_temp(conv_temp), .conv_run(conv_run), .event_pin(event_pin));
	tsr_host_model i_tsr_host_model (.clk_sys(clk_sys), .ptr_wr(ptr_wr), .ptr_data(ptr_data),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata));

	////////////////////////////////////////////////////////////////
	// expectation queue, sampled once the result has settled
	task automatic expect_val(input logic [1:0] s, input logic [15:0] v);
		exp_q.push_back('{s, v});
		repeat (4) @(negedge clk_sys);
		-> look_ev;
	endtask

	task automatic rd(input logic [3:0] p, input logic [15:0] v);
		i_tsr_host_model.set_ptr(p);
		expect_val(2'd0, v);
	endtask

	task automatic sample(input logic [10:0] t);
		@(negedge clk_sys);
		conv_temp = t;
		conv_valid = 1'b1;
		@(negedge clk_sys);
		conv_valid = 1'b0;
		conv_temp = ~t;
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	always @(look_ev) begin
		e = exp_q.pop_front();
		got = (e.sel == 2'd0) ? reg_rdata : (e.sel == 2'd1) ? {15'h0000, event_pin} : {15'h0000, conv_run};
		checks_done++;
		if (got !== e.val) begin
			fail_count++;
			$display("[FAIL] %0t sel %0d got %h expected %h", $time, e.sel, got, e.val);
		end
	end

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h78DA));
		repeat (5) @(negedge clk_sys);
		rst_n = 1'b1;
		rd(PTR_CAP, 16'h000F);
		i_tsr_host_model.wr(PTR_CAP, 16'hFFFF);
		rd(PTR_CAP, 16'h000F);
		rd(PTR_MAKER, 16'h00C3);
		rd(PTR_PART, 16'h3C02);
		rd(4'h9, 16'h0000);
		$display("identity test done");
		for (int r = 0; r < 4; r++) begin
			i_tsr_host_model.wr(PTR_RES, 16'($urandom) & 16'hFFFC | 16'(r));
			rd(PTR_RES, 16'(r));
			rd(PTR_CAP, {11'h000, 2'(r), 3'h7});
		end
		$display("resolution test done");
		sample(11'h050);
		rd(PTR_AMB, 16'hC140);
		i_tsr_host_model.wr(PTR_SETUP, 16'h0608);
		rd(PTR_SETUP, 16'h0618);
		expect_val(2'd1, 16'h0000);
		i_tsr_host_model.wr(PTR_SETUP, 16'h0100);
		expect_val(2'd2, 16'h0000);
		sample(11'h7F0);
		rd(PTR_AMB, 16'hC140);
		rd(PTR_SETUP, 16'h0100);
		i_tsr_host_model.wr(PTR_SETUP, 16'h0000);
		expect_val(2'd2, 16'h0001);
		$display("setup test done");
		// upper limit written last so lim keeps its value for the lock test
		for (int p = 4; p > 1; p--) begin
			lim = 16'($urandom);
			i_tsr_host_model.wr(4'(p), lim);
			rd(4'(p), lim & LIMIT_MASK);
		end
		$display("limit test done");
		i_tsr_host_model.wr(PTR_SETUP, 16'h00C0);
		rd(PTR_SETUP, 16'h00C0);
		i_tsr_host_model.wr(PTR_UPPER, 16'h0AAC);
		rd(PTR_UPPER, lim & LIMIT_MASK);
		i_tsr_host_model.wr(PTR_SETUP, 16'h0100);
		rd(PTR_SETUP, 16'h00C0);
		@(negedge clk_sys);
		rst_n = 1'b0;
		@(negedge clk_sys);
		rst_n = 1'b1;
		rd(PTR_SETUP, 16'h0000);
		i_tsr_host_model.wr(PTR_UPPER, 16'h0AAC);
		rd(PTR_UPPER, 16'h0AAC);
		$display("lock test done");
		i_tsr_host_model.wr(PTR_CRIT, 16'h0FFC);
		i_tsr_host_model.wr(PTR_SETUP, 16'h0009);
		expect_val(2'd1, 16'h0001);
		sample(11'h7F0);
		expect_val(2'd1, 16'h0000);
		sample(11'h050);
		expect_val(2'd1, 16'h0000);
		i_tsr_host_model.wr(PTR_SETUP, 16'h0029);
		expect_val(2'd1, 16'h0001);
		$display("interrupt test done");
		test_done();
	end
endmodule
`default_nettype wire
